// *** shared/tap_regs.vh ***
// Constants of the test access port: instruction codes, widths and ID word layout.
`ifndef TAP_REGS_VH
`define TAP_REGS_VH
`define IR_WIDTH        3
`define IR_CAPTURE_BITS 2'h1
`define INS_EXTEST      3'h0
`define INS_IDCODE      3'h1
`define INS_SAMPLE_Z    3'h2
`define INS_RSVD_A      3'h3
`define INS_SAMPLE_PRE  3'h4
`define INS_PRIVATE     3'h5
`define INS_RSVD_B      3'h6
`define INS_BYPASS      3'h7
`define ID_WIDTH        32
`define ID_VENDOR_LSB   1
`define ID_VENDOR_MSB   11
`define ID_PRESENCE_BIT 0
`define RESET_TMS_EDGES 5
`endif

// *** hw/pin_sync.v ***
// Two-stage synchroniser for a group of asynchronous pin inputs.
`timescale 1ns/100ps
module pin_sync #(
   parameter WIDTH = 1
) (
   // Clock and reset.
   input  wire             sys_clk,
   input  wire             rst,
   // Pins in and synchronised copies out.
   input  wire [WIDTH-1:0] async_in,
   output reg  [WIDTH-1:0] sync_out
);
   reg [WIDTH-1:0] meta_q;

   // The first stage feeds only the second, so a metastable level never reaches logic.
   always @(posedge sys_clk) begin
      if (rst) begin
         meta_q   <= {WIDTH{1'b1}};
         sync_out <= {WIDTH{1'b1}};
      end else begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule

// *** hw/sram_boundary_scan_tap.v ***
// Test access port controller with instruction, ID, bypass and boundary registers.
`timescale 1ns/100ps
`include "tap_regs.vh"
// What this block does
// - Capture-IR loads low bits with 01
// - Shift-IR shifts instruction between TDI, TDO
// - New instruction active only at Update-IR
// - Codes read MSB left, LSB right
// - Code 000 selects EXTEST, boundary register
// - Code 001 IDCODE captures and shifts ID
// - IDCODE loaded at reset and test-logic-reset
// - Code 010 floats outputs, boundary register shifts
// - Reserved codes 011, 110 act as bypass
// - Code 100 samples pins into boundary register
// - Code 111 puts bypass bit in path
// - Unattached boundary cells capture fixed defaults
// - EXTEST never overrides RAM input pins
// - EXTEST drives boundary outputs at Update-IR fall
// - EXTEST captures pins and defaults on rise
// - Instruction register is three bits
// - Five high TMS edges reset controller
// - TMS/TDI on rise, TDO after fall
// - Device_identification_word 32 bits, LSB first
module sram_boundary_scan_tap #(
   parameter                       N_IN   = 8,
   parameter                       N_OUT  = 8,
   parameter                       N_FIX  = 2,
   parameter [10:0]                VENDOR = 11'h2A5,   // Arbitrary neutral value.
   parameter [N_FIX-1:0]           FIX_DEFAULT = {N_FIX{1'b1}}
) (
   // System clock and reset.
   input  wire                     sys_clk,
   input  wire                     rst,
   // Test port pins.
   input  wire                     tck,
   input  wire                     tms,
   input  wire                     tdi,
   output reg                      tdo,
   output reg                      tdo_oe,
   // RAM side: input and I/O pin levels, functional output data.
   input  wire [N_IN-1:0]          ram_pins_in,
   input  wire [N_OUT-1:0]         ram_core_out,
   input  wire                     ram_core_oe,
   // RAM output driver control.
   output reg  [N_OUT-1:0]         ram_drive_out,
   output reg                      ram_drive_oe,
   // Current instruction, for observation.
   output reg  [`IR_WIDTH-1:0]     active_ins
);
   localparam BSR_LEN = N_IN + N_OUT + N_FIX;
   // One-hot TAP states.
   localparam [15:0] S_TLR = 16'h0001, S_RTI = 16'h0002, S_SDR = 16'h0004, S_CDR = 16'h0008,
                     S_SHD = 16'h0010, S_E1D = 16'h0020, S_PDR = 16'h0040, S_E2D = 16'h0080,
                     S_UDR = 16'h0100, S_SIR = 16'h0200, S_CIR = 16'h0400, S_SHI = 16'h0800,
                     S_E1I = 16'h1000, S_PIR = 16'h2000, S_E2I = 16'h4000, S_UIR = 16'h8000;

   wire [2:0]          pins_s;
   reg                 tck_q;
   reg  [15:0]         state_q, state_d;
   reg  [`IR_WIDTH-1:0] ir_sh_q;
   reg  [`ID_WIDTH-1:0] id_q;
   reg                 byp_q;
   reg  [BSR_LEN-1:0]  bsr_q;
   reg  [N_OUT-1:0]    upd_q;
   reg                 tdo_d;
   reg                 ext_drive_q;
   wire                rise = pins_s[2] & ~tck_q;
   wire                fall = ~pins_s[2] & tck_q;
   wire                tms_s = pins_s[1];
   wire                tdi_s = pins_s[0];
   wire [`ID_WIDTH-1:0] id_rom = {20'h00000, VENDOR, 1'b1};

   // Decode the boundary register users; reserved and private codes fall to bypass.
   function [1:0] path_sel;
      input [`IR_WIDTH-1:0] ins;
      begin
         case (ins)
            `INS_EXTEST, `INS_SAMPLE_Z, `INS_SAMPLE_PRE: path_sel = 2'h2;
            `INS_IDCODE: path_sel = 2'h1;
            default: path_sel = 2'h0;
         endcase
      end
   endfunction

   // Pins pass two flip-flops; TCK edges are found from the synchronised copy.
   pin_sync #(.WIDTH(3)) u_sync (
      .sys_clk  (sys_clk),
      .rst      (rst),
      .async_in ({tck, tms, tdi}),
      .sync_out (pins_s)
   );

   // Next TAP state on a TCK rising edge.
   always @* begin
      case (state_q)
         S_TLR: state_d = tms_s ? S_TLR : S_RTI;
         S_RTI: state_d = tms_s ? S_SDR : S_RTI;
         S_SDR: state_d = tms_s ? S_SIR : S_CDR;
         S_CDR: state_d = tms_s ? S_E1D : S_SHD;
         S_SHD: state_d = tms_s ? S_E1D : S_SHD;
         S_E1D: state_d = tms_s ? S_UDR : S_PDR;
         S_PDR: state_d = tms_s ? S_E2D : S_PDR;
         S_E2D: state_d = tms_s ? S_UDR : S_SHD;
         S_UDR: state_d = tms_s ? S_SDR : S_RTI;
         S_SIR: state_d = tms_s ? S_TLR : S_CIR;
         S_CIR: state_d = tms_s ? S_E1I : S_SHI;
         S_SHI: state_d = tms_s ? S_E1I : S_SHI;
         S_E1I: state_d = tms_s ? S_UIR : S_PIR;
         S_PIR: state_d = tms_s ? S_E2I : S_PIR;
         S_E2I: state_d = tms_s ? S_UIR : S_SHI;
         S_UIR: state_d = tms_s ? S_SDR : S_RTI;
         default: state_d = S_TLR;
      endcase
   end

   // Five high TMS edges reach reset from any state through the graph above.
   always @(posedge sys_clk) begin
      if (rst) begin
         // The synchroniser resets high, so the edge finder must too, or a false rise follows reset.
         tck_q   <= 1'b1;
         state_q <= S_TLR;
      end else begin
         tck_q <= pins_s[2];
         if (rise)
            state_q <= state_d;
      end
   end

   // Capture and shift on rising TCK edges.
   always @(posedge sys_clk) begin
      if (rst) begin
         ir_sh_q <= `INS_IDCODE;
         id_q    <= {`ID_WIDTH{1'b0}};
         byp_q   <= 1'b0;
         bsr_q   <= {BSR_LEN{1'b0}};
      end else if (rise) begin
         if (state_q == S_CIR)
            ir_sh_q <= {1'b0, `IR_CAPTURE_BITS};
         else if (state_q == S_SHI)
            ir_sh_q <= {tdi_s, ir_sh_q[`IR_WIDTH-1:1]};
         if (state_q == S_CDR) begin
            id_q  <= id_rom;
            byp_q <= 1'b0;
            // Pins, output cells and fixed defaults captured.
            if (path_sel(active_ins) == 2'h2)
               bsr_q <= {FIX_DEFAULT, ram_core_out, ram_pins_in};
         end else if (state_q == S_SHD) begin
            id_q  <= {tdi_s, id_q[`ID_WIDTH-1:1]};
            byp_q <= tdi_s;
            bsr_q <= {tdi_s, bsr_q[BSR_LEN-1:1]};
         end
      end
   end

   // Instruction changes at Update-IR or reset only; outputs update on fall.
   always @(posedge sys_clk) begin
      if (rst) begin
         active_ins  <= `INS_IDCODE;
         upd_q       <= {N_OUT{1'b0}};
         ext_drive_q <= 1'b0;
      end else if (fall) begin
         if (state_q == S_TLR)
            active_ins <= `INS_IDCODE;
         else if (state_q == S_UIR)
            active_ins <= ir_sh_q;
         if (state_q == S_UIR || state_q == S_UDR)
            upd_q <= bsr_q[N_IN+N_OUT-1:N_IN];
         if (state_q == S_TLR)
            ext_drive_q <= 1'b0;
         else if (state_q == S_UIR)
            ext_drive_q <= (ir_sh_q == `INS_EXTEST);
      end
   end

   always @* begin
      tdo_d = byp_q;
      if (state_q == S_SHI)
         tdo_d = ir_sh_q[0];
      else if (path_sel(active_ins) == 2'h1)
         tdo_d = id_q[0];
      else if (path_sel(active_ins) == 2'h2)
         tdo_d = bsr_q[0];
   end

   // TDO launched on falling TCK, enabled only in shift states.
   always @(posedge sys_clk) begin
      if (rst) begin
         tdo    <= 1'b0;
         tdo_oe <= 1'b0;
      end else if (fall) begin
         tdo    <= tdo_d;
         tdo_oe <= (state_q == S_SHI) || (state_q == S_SHD);
      end
   end

   // RAM inputs are never touched; floats outputs; EXTEST drives cells.
   always @(posedge sys_clk) begin
      if (rst) begin
         ram_drive_out <= {N_OUT{1'b0}};
         ram_drive_oe  <= 1'b0;
      end else if (active_ins == `INS_SAMPLE_Z) begin
         ram_drive_out <= ram_core_out;
         ram_drive_oe  <= 1'b0;
      end else if (ext_drive_q) begin
         ram_drive_out <= upd_q;
         ram_drive_oe  <= 1'b1;
      end else begin
         ram_drive_out <= ram_core_out;
         ram_drive_oe  <= ram_core_oe;
      end
   end
endmodule

// *** verif/tap_chk_properties.sv ***
// Checker of the test port timing and instruction effects.
`timescale 1ns/100ps
`include "tap_regs.vh"
module tap_chk #(parameter N_IN = 8, parameter N_OUT = 8) (
   // Clock and reset.
   input wire             sys_clk,
   input wire             rst,
   // Test port.
   input wire             tck,
   input wire             tms,
   input wire             tdi,
   input wire             tdo,
   input wire             tdo_oe,
   // RAM side.
   input wire [N_IN-1:0]  ram_pins_in,
   input wire [N_OUT-1:0] ram_core_out,
   input wire             ram_core_oe,
   input wire [N_OUT-1:0] ram_drive_out,
   input wire             ram_drive_oe,
   input wire [2:0]       active_ins
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   wire      func = active_ins != `INS_EXTEST && active_ins != `INS_SAMPLE_Z;
   reg [2:0] hi_q;
   // Raw pin count of test clock rises with mode high; it saturates at five.
   always @(posedge sys_clk) begin
      if (rst)
         hi_q <= 3'h0;
      else if (tck && !$past(tck))
         hi_q <= !tms ? 3'h0 : (hi_q == 3'h5 ? hi_q : hi_q + 3'h1);
   end
   property p_rst; $fell(rst) |-> active_ins == `INS_IDCODE && !tdo_oe && !ram_drive_oe; endproperty
   a_rst: assert property (p_rst) else $error("bad state after reset");
   property p_ins; active_ins != $past(active_ins) |-> !tck; endproperty
   a_ins: assert property (p_ins) else $error("instruction moved off a fall");
   property p_tdo; $changed(tdo) |-> !tck; endproperty
   a_tdo: assert property (p_tdo) else $error("data out moved while clock high");
   property p_tlr; $rose(hi_q == 3'h5) |-> ##[1:40] active_ins == `INS_IDCODE; endproperty
   a_tlr: assert property (p_tlr) else $error("no reload after five high edges");
   property p_hiz; active_ins == `INS_SAMPLE_Z |=> !ram_drive_oe; endproperty
   a_hiz: assert property (p_hiz) else $error("outputs driven under high-z");
   property p_ext; active_ins == `INS_EXTEST |=> ram_drive_oe; endproperty
   a_ext: assert property (p_ext) else $error("outputs idle under external test");
   property p_exh; active_ins == 3'h0 && $past(active_ins) == 3'h0 && $changed(ram_drive_out) |-> !tck; endproperty
   a_exh: assert property (p_exh) else $error("driven data moved while clock high");
   // The edge after reset still shows the reset drive value, so it is left out.
   property p_fn; !$past(rst) && func && $past(func) |-> ram_drive_out == $past(ram_core_out) &&
      ram_drive_oe == $past(ram_core_oe);
   endproperty
   a_fn: assert property (p_fn) else $error("functional outputs not passed");
   c_ext: cover property (active_ins == `INS_EXTEST);
   c_hiz: cover property (active_ins == `INS_SAMPLE_Z);
   c_shf: cover property (tdo_oe);
endmodule
bind sram_boundary_scan_tap tap_chk #(.N_IN(N_IN), .N_OUT(N_OUT)) chk (.sys_clk(sys_clk), .rst(rst), .tck(tck),
   .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .ram_pins_in(ram_pins_in), .ram_core_out(ram_core_out),
   .ram_core_oe(ram_core_oe), .ram_drive_out(ram_drive_out), .ram_drive_oe(ram_drive_oe), .active_ins(active_ins));

// *** verif/scan_ctl.sv ***
// Scan controller model that walks the test port one test clock at a time.
`timescale 1ns/100ps
module scan_ctl (
   // Pacing clock.
   input wire sys_clk,
   // Test port.
   output reg tck,
   output reg tms,
   output reg tdi,
   input wire tdo,
   input wire tdo_oe
);
   // Test clock rests low between frames; mode and data rest high as if pulled up.
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b1;
   end
   task step(input m, input d, output q);
      begin
         tms <= m;
         tdi <= d;
         repeat (5) @(posedge sys_clk);
         // An undriven data out has no pull, so it reads inverted and a missing enable shows up.
         q = tdo_oe ? tdo : ~tdo;
         tck <= 1'b1;
         repeat (10) @(posedge sys_clk);
         tck <= 1'b0;
         repeat (5) @(posedge sys_clk);
      end
   endtask
endmodule

// *** verif/testbench.sv ***
// Bench that loads every instruction and scans its data register.
`timescale 1ns/100ps
`include "tap_regs.vh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_fail++; $display("unexpected at %0t: %h vs %h", $time, g, e); end end
module testbench;
   localparam [10:0] VEND = 11'h155; // Arbitrary vendor value.
   reg        sys_clk = 1'b0;
   reg        rst = 1'b1;
   reg [7:0]  pins = 8'h3C;
   reg [7:0]  core = 8'h96;
   reg        core_oe = 1'b1;
   wire       tck, tms, tdi, tdo, tdo_oe, drv_oe;
   wire [7:0] drv;
   wire [2:0] ins;
   integer    n_fail = 0, n_compared = 0, cyc = 0, k, c;
   reg [31:0] got;
   reg [2:0]  cur = 3'h1;
   reg        b;
   always #4 sys_clk = ~sys_clk;
   sram_boundary_scan_tap #(.VENDOR(VEND)) uut (.sys_clk(sys_clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi),
      .tdo(tdo), .tdo_oe(tdo_oe), .ram_pins_in(pins), .ram_core_out(core), .ram_core_oe(core_oe),
      .ram_drive_out(drv), .ram_drive_oe(drv_oe), .active_ins(ins));
   scan_ctl ctl (.sys_clk(sys_clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));
   task wrap_up;
      begin
         $display("compared %0d, mismatched %0d", n_compared, n_fail);
         if (n_fail == 0 && n_compared > 0)
            $display("TEST PASSED");
         else
            $display("TEST FAILED");
         $finish;
      end
   endtask
   // A hang is cut short well past the expected run.
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         n_fail++;
         wrap_up;
      end
   end
   // Mode bits go out low bit first.
   task walk(input integer n, input [7:0] m);
      for (k = 0; k < n; k++) ctl.step(m[k], 1'b1, b);
   endtask
   // Shift n bits low first, leaving the shift state on the last.
   task bits(input integer n, input [31:0] din);
      begin
         got = 32'h0;
         for (k = 0; k < n; k++) begin
            ctl.step(k == n - 1, din[k], b);
            got[k] = b;
         end
      end
   endtask
   task ir(input [2:0] code);
      begin
         walk(4, 8'h03);
         bits(3, {29'h0, code});
         `CHK(got[2:0], 3'h1)
         `CHK(ins, cur)
         walk(2, 8'h01);
         `CHK(ins, code)
         cur = code;
      end
   endtask
   initial begin
      repeat (12) @(posedge sys_clk);
      rst <= 1'b0;
      repeat (4) @(posedge sys_clk);
      `CHK(ins, `INS_IDCODE)
      walk(1, 8'h00);
      for (c = 0; c < 8; c++) begin
         ir(c[2:0]);
         walk(3, 8'h01);
         if (c == 1) begin
            bits(32, 32'h5A5A5A5A);
            `CHK(got, {20'h0, VEND, 1'b1})
         end else if (c == 0 || c == 2 || c == 4) begin
            bits(18, 32'h5A5A5A5A);
            `CHK(got, {14'h0, 2'b11, core, pins})
         end else begin
            bits(4, 32'h5A5A5A5A);
            `CHK(got, 32'h4)
         end
         // The functional enable drops here, so a driver enable stuck high would be seen.
         if (c == 4)
            core_oe <= 1'b0;
         walk(2, 8'h01);
         if (c == 0)
            `CHK({drv_oe, drv}, 9'h15A)
         if (c == 2)
            `CHK(drv_oe, 1'b0)
         if (c == 4)
            `CHK({drv_oe, drv}, {core_oe, core})
         $display("code %0d done", c);
      end
      walk(5, 8'h1F);
      repeat (4) @(posedge sys_clk);
      `CHK(ins, `INS_IDCODE)
      $display("mode reset done");
      wrap_up;
   end
endmodule
